//--- core/wcs_modes.sv
/*
  Mode logic of a dual-encoder preset counter: radius, cut-to-length and slip.
  Assumes settings are stable inputs on core_clk; pins are asynchronous.
*/
// What this block does
// - Radius mode: radius from encoder-1 lines per trigger; encoder 2 ignored.
// - Core radius zero shows full radius, else full minus core.
// - Radius mode tracks min and max radius, line total and lines per turn.
// - Radius mode: presets one, two on line count; three, four on radius.
// - Radius mode five entries; fast red min, fast yellow max, slow last two.
// - Cut variant A counts up from zero to cut length plus tool width.
// - Cut variant B starts at minus tool width, counts to cut length.
// - Slow down at prestop distance before target; correct stop for overshoot.
// - Cut modes ignore user presets; presets hold internal targets.
// - Start comes from any input mapped to reset, or timed auto restart.
// - Cut: outputs two, three active at or below preset, four at or above; one unused.
// - Cut reset loads preselection value rather than zero.
// - Cut modes show and output only position; list holds present, min, max.
// - Slip mode: all presets compare against encoder-1 minus encoder-2.
// - Each encoder scaled before subtraction; optional final scaling after.
// - Slip presets are signed, so lead and lag are both detectable.
// - Slip mode resets counters every interval tenths; zero disables, max 99.9 s.
// - Refresh zero or any mode but slip is real time; else 8 ms doubled per step.
// - Slip mode five entries: diff, min, max, encoder one, encoder two.
`timescale 1ns/100ps
`default_nettype none
module wcs_modes #(
  parameter int DISP_BASE_CYC = wcs_pkg::DISP_BASE_CYC,
  parameter int TENTH_CYC     = wcs_pkg::TENTH_CYC,
  parameter int CUT_DWELL_CYC = wcs_pkg::CUT_DWELL_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic [3:0]                operating_mode_select,
  input  wire logic [1:0]                enc_a_pin,
  input  wire logic [1:0]                enc_b_pin,
  input  wire logic                      roll_trigger_pin,
  input  wire logic [wcs_pkg::NCMD-1:0]  cmd_pin,
  input  wire logic [wcs_pkg::NCMD-1:0]  cmd_is_reset,
  input  wire logic [wcs_pkg::NCMD-1:0]  cmd_is_scroll,
  input  wire logic [wcs_pkg::SCL_W-1:0] impulse_scale_1,
  input  wire logic [wcs_pkg::SCL_W-1:0] impulse_scale_2,
  input  wire logic                      final_scale_en,
  input  wire logic [wcs_pkg::SCL_W-1:0] final_scale,
  input  wire logic [wcs_pkg::SCL_W-1:0] auto_scale_param_a,
  input  wire logic [4:0]                auto_scale_param_b,
  input  wire wcs_pkg::wcs_cnt_t         core_radius_setting,
  input  wire wcs_pkg::wcs_presets_t     user_presets,
  input  wire wcs_pkg::wcs_cut_cfg_t     cut_cfg,
  input  wire logic                      reset_load_select,
  input  wire wcs_pkg::wcs_out_cfg_t     out_cfg,
  input  wire logic                      auto_cut_restart,
  input  wire logic [9:0]                auto_reset_interval,
  input  wire logic [3:0]                display_refresh_rate,
  output logic [3:0]                     drive_out,
  output wcs_pkg::wcs_cnt_t              disp_value,
  output logic [2:0]                     disp_entry,
  output logic                           red_indicator,
  output logic                           yellow_indicator,
  output wcs_pkg::wcs_cnt_t              analog_value
);
  import wcs_pkg::*;

  logic [1:0]      step;
  logic [1:0]      up;
  logic [NCMD-1:0] cmd_s1_q;
  logic [NCMD-1:0] cmd_s2_q;
  logic [NCMD-1:0] cmd_prev_q;
  logic [2:0]      trig_q;
  wcs_cnt_t        cnt_q [2];
  wcs_cnt_t        rev_start_q;
  wcs_cnt_t        per_rev_q;
  wcs_cnt_t        radius_q;
  wcs_cnt_t        mm_min_q;
  wcs_cnt_t        mm_max_q;
  logic            mm_valid_q;
  wcs_cnt_t        track_val;
  logic            track_upd;
  wcs_cut_st_t     cut_st_q;
  logic [31:0]     dwell_q;
  logic [31:0]     base_div_q;
  logic            base_tick;
  logic [7:0]      blink_q;
  logic [31:0]     tenth_div_q;
  logic [9:0]      tenths_q;
  logic [11:0]     refresh_q;
  wcs_presets_t    presets;
  wcs_cnt_t        cmp_val [4];
  logic [3:0]      active;
  logic [3:0]      active_q;
  wcs_cnt_t        scaled [2];
  wcs_cnt_t        diff;
  wcs_cnt_t        diff_eng;
  wcs_cnt_t        cut_target;
  wcs_cnt_t        load_val;
  wcs_cnt_t        sel_val;
  logic            is_cut;
  logic            start_cmd;
  logic            scroll_cmd;
  logic            trig_rise;
  logic            trig_rise_q;
  logic            auto_rst;
  logic            disp_upd;
  logic [2:0]      n_entries;
  logic [2:0]      entry_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_enc
      wcs_quad_dec u_dec (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .a_pin    (enc_a_pin[gi]),
        .b_pin    (enc_b_pin[gi]),
        .step     (step[gi]),
        .up       (up[gi])
      );
      // Impulse scaling per encoder, Q8.8 factor.
      assign scaled[gi] = CNT_W'((64'(cnt_q[gi]) * 64'(signed'({1'b0, (gi == 0) ?
                          impulse_scale_1 : impulse_scale_2}))) >>> FRAC_BITS);
    end
  endgenerate

  // Command and trigger pins pass two flops before edge detection.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cmd_s1_q   <= '0;
      cmd_s2_q   <= '0;
      cmd_prev_q <= '0;
      trig_q     <= 3'h0;
      trig_rise_q <= 1'b0;
    end else begin
      cmd_s1_q   <= cmd_pin;
      cmd_s2_q   <= cmd_s1_q;
      cmd_prev_q <= cmd_s2_q;
      trig_q     <= {trig_q[1:0], roll_trigger_pin};
      trig_rise_q <= trig_rise;
    end
  end

  assign start_cmd  = |(cmd_s2_q & ~cmd_prev_q & cmd_is_reset);
  assign scroll_cmd = |(cmd_s2_q & ~cmd_prev_q & cmd_is_scroll);
  assign trig_rise  = trig_q[1] & ~trig_q[2];
  assign is_cut     = (operating_mode_select == MODE_CUT_A) ||
                      (operating_mode_select == MODE_CUT_B);

  // Cut targets: variant A adds the tool width, variant B preloads its negative.
  assign cut_target = (operating_mode_select == MODE_CUT_A) ?
                      cut_cfg.cut_length + cut_cfg.tool_width : cut_cfg.cut_length;
  assign load_val   = (reset_load_select && operating_mode_select == MODE_CUT_B) ?
                      -cut_cfg.tool_width : '0;

  // Base 8 ms tick; also drives blinking and refresh.
  assign base_tick = (base_div_q == 32'(DISP_BASE_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      base_div_q <= 32'h0;
      blink_q    <= 8'h0;
    end else if (base_tick) begin
      base_div_q <= 32'h0;
      blink_q    <= blink_q + 8'h1;
    end else begin
      base_div_q <= base_div_q + 32'h1;
    end
  end

  // Periodic counter reset in slip mode, counted in tenths of a second.
  always_ff @(posedge core_clk) begin
    if (!rst_b || operating_mode_select != MODE_SLIP || auto_reset_interval == 10'h0) begin
      tenth_div_q <= 32'h0;
      tenths_q    <= 10'h0;
    end else if (tenth_div_q == 32'(TENTH_CYC - 1)) begin
      tenth_div_q <= 32'h0;
      tenths_q    <= auto_rst ? 10'h0 : tenths_q + 10'h1;
    end else begin
      tenth_div_q <= tenth_div_q + 32'h1;
    end
  end
  assign auto_rst = (operating_mode_select == MODE_SLIP) && (auto_reset_interval != 10'h0) &&
                    (tenth_div_q == 32'(TENTH_CYC - 1)) &&
                    (tenths_q + 10'h1 >= ((auto_reset_interval > AUTO_RST_MAX) ?
                    AUTO_RST_MAX : auto_reset_interval));

  // Cut sequence: run to the stop preset, dwell with output four, restart if automatic.
  always_ff @(posedge core_clk) begin
    if (!rst_b || !is_cut) begin
      cut_st_q <= CUT_IDLE;
      dwell_q  <= 32'h0;
    end else begin
      case (cut_st_q)
        CUT_IDLE: begin
          if (start_cmd) begin
            cut_st_q <= CUT_RUN;
          end
        end
        CUT_RUN: begin
          dwell_q <= 32'h0;
          if (active[3]) begin
            cut_st_q <= CUT_DWELL;
          end
        end
        CUT_DWELL: begin
          dwell_q <= dwell_q + 32'h1;
          if (start_cmd || (auto_cut_restart && dwell_q == 32'(CUT_DWELL_CYC - 1))) begin
            cut_st_q <= CUT_RUN;
          end
        end
        default: begin
          cut_st_q <= CUT_IDLE;
        end
      endcase
    end
  end

  // Encoder counters; encoder 2 only counts in slip mode.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
    end else if (start_cmd || auto_rst ||
                 (cut_st_q == CUT_DWELL && auto_cut_restart &&
                  dwell_q == 32'(CUT_DWELL_CYC - 1))) begin
      cnt_q[0] <= is_cut ? load_val : '0;
      cnt_q[1] <= '0;
    end else begin
      if (step[0]) begin
        cnt_q[0] <= up[0] ? cnt_q[0] + 1 : cnt_q[0] - 1;
      end
      if (step[1] && operating_mode_select == MODE_SLIP) begin
        cnt_q[1] <= up[1] ? cnt_q[1] + 1 : cnt_q[1] - 1;
      end
    end
  end

  // Radius from lines per roll turn: lines times factor, shifted by the divisor exponent.
  always_ff @(posedge core_clk) begin
    if (!rst_b || (start_cmd && operating_mode_select == MODE_RADIUS)) begin
      rev_start_q <= '0;
      per_rev_q   <= '0;
      radius_q    <= '0;
    end else if (trig_rise && operating_mode_select == MODE_RADIUS) begin
      rev_start_q <= cnt_q[0];
      per_rev_q   <= cnt_q[0] - rev_start_q;
      radius_q    <= CNT_W'((64'(cnt_q[0] - rev_start_q) *
                     64'(signed'({1'b0, auto_scale_param_a}))) >>> auto_scale_param_b)
                     - core_radius_setting;
    end
  end

  assign diff     = scaled[0] - scaled[1];
  assign diff_eng = final_scale_en ?
                    CNT_W'((64'(diff) * 64'(signed'({1'b0, final_scale}))) >>> FRAC_BITS) :
                    diff;

  // Value whose extremes are recorded, and when it is sampled.
  always_comb begin
    track_val = cnt_q[0];
    track_upd = 1'b1;
    case (operating_mode_select)
      MODE_RADIUS: begin
        track_val = radius_q;
        // Sampled one cycle after the trigger, so the freshly computed radius is seen.
        track_upd = trig_rise_q;
      end
      MODE_SLIP: begin
        track_val = diff_eng;
      end
      default: begin
        track_val = cnt_q[0];
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || start_cmd) begin
      mm_valid_q <= 1'b0;
      mm_min_q   <= '0;
      mm_max_q   <= '0;
    end else if (track_upd) begin
      mm_valid_q <= 1'b1;
      mm_min_q   <= (!mm_valid_q || track_val < mm_min_q) ? track_val : mm_min_q;
      mm_max_q   <= (!mm_valid_q || track_val > mm_max_q) ? track_val : mm_max_q;
    end
  end

  // Preset sources per mode; cut modes overwrite presets with internal targets.
  always_comb begin
    presets    = user_presets;
    cmp_val[0] = cnt_q[0];
    cmp_val[1] = cnt_q[0];
    cmp_val[2] = cnt_q[0];
    cmp_val[3] = cnt_q[0];
    case (operating_mode_select)
      MODE_RADIUS: begin
        cmp_val[2] = radius_q;
        cmp_val[3] = radius_q;
      end
      MODE_CUT_A, MODE_CUT_B: begin
        presets[0] = cut_target;
        presets[1] = cut_target - cut_cfg.prestop_distance;
        presets[2] = cut_target - cut_cfg.overshoot_correction - 1;
        presets[3] = cut_target - cut_cfg.overshoot_correction;
      end
      MODE_SLIP: begin
        cmp_val[0] = diff_eng;
        cmp_val[1] = diff_eng;
        cmp_val[2] = diff_eng;
        cmp_val[3] = diff_eng;
      end
      default: begin
        presets = user_presets;
      end
    endcase
  end

  // Signed comparison; outside cut modes the sense bit chooses at-or-below instead of at-or-above.
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      assign active[gi] = (is_cut && gi == 0) ? 1'b0 :
                          (is_cut && (gi == 1 || gi == 2)) ? (cmp_val[gi] <= presets[gi]) :
                          (is_cut && gi == 3) ? (cmp_val[gi] >= presets[gi]) :
                          out_cfg.compare_sense[gi] ? (cmp_val[gi] <= presets[gi]) :
                          (cmp_val[gi] >= presets[gi]);
    end
  endgenerate

  // Pulse mode gives one cycle at activation; cut outputs two and three stay static.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      active_q  <= 4'h0;
      drive_out <= 4'h0;
    end else begin
      active_q  <= active;
      for (int i = 0; i < 4; i++) begin
        drive_out[i] <= (out_cfg.pulse_mode[i] && !(is_cut && i != 3)) ?
                        (active[i] & ~active_q[i]) : active[i];
      end
    end
  end

  // Display refresh: real time at zero or outside slip mode, else 8 ms times two to the (n-1).
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      refresh_q <= 12'h0;
    end else if (base_tick) begin
      refresh_q <= disp_upd ? 12'h0 : refresh_q + 12'h1;
    end
  end
  assign disp_upd = (operating_mode_select != MODE_SLIP) || (display_refresh_rate == 4'h0) ||
                    (base_tick && (refresh_q + 12'h1 >= (12'h1 << ((display_refresh_rate >
                    REFRESH_MAX ? REFRESH_MAX : display_refresh_rate) - 4'h1))));

  assign n_entries = is_cut ? ENT_N3 : ENT_N5;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      entry_q <= ENT_MAIN;
    end else if (entry_q >= n_entries) begin
      entry_q <= ENT_MAIN;
    end else if (scroll_cmd) begin
      entry_q <= (entry_q + 3'h1 >= n_entries) ? ENT_MAIN : entry_q + 3'h1;
    end
  end

  always_comb begin
    sel_val = cnt_q[0];
    case (entry_q)
      ENT_MAIN: begin
        sel_val = (operating_mode_select == MODE_RADIUS) ? radius_q :
                  (operating_mode_select == MODE_SLIP) ? diff_eng : cnt_q[0];
      end
      ENT_MIN:  sel_val = mm_min_q;
      ENT_MAX:  sel_val = mm_max_q;
      ENT_AUX1: sel_val = (operating_mode_select == MODE_SLIP) ? scaled[0] : cnt_q[0];
      ENT_AUX2: sel_val = (operating_mode_select == MODE_SLIP) ? scaled[1] : per_rev_q;
      default:  sel_val = cnt_q[0];
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      disp_value       <= '0;
      disp_entry       <= ENT_MAIN;
      red_indicator    <= 1'b0;
      yellow_indicator <= 1'b0;
      analog_value     <= '0;
    end else begin
      if (disp_upd) begin
        disp_value <= sel_val;
      end
      disp_entry       <= entry_q;
      red_indicator    <= (entry_q == ENT_MIN  && blink_q[BLINK_FAST_BIT]) ||
                          (entry_q == ENT_AUX1 && blink_q[BLINK_SLOW_BIT]);
      yellow_indicator <= (entry_q == ENT_MAX  && blink_q[BLINK_FAST_BIT]) ||
                          (entry_q == ENT_AUX2 && blink_q[BLINK_SLOW_BIT]);
      analog_value     <= is_cut ? cnt_q[0] : sel_val;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  cut_out1_off_a: assert property (is_cut |=> !drive_out[0])
    else $error("Output one driven in cut mode.");
  cut_start_a: assert property (start_cmd && operating_mode_select == MODE_CUT_B &&
      reset_load_select |=> cnt_q[0] == -$past(cut_cfg.tool_width))
    else $error("Variant B start did not load negative tool width.");
  cut_a_zero_a: assert property (start_cmd && operating_mode_select == MODE_CUT_A
      |=> cnt_q[0] == 0)
    else $error("Variant A start did not clear the count.");
  cut_stop_a: assert property (is_cut && !out_cfg.pulse_mode[3] &&
      cnt_q[0] >= cut_target - cut_cfg.overshoot_correction |=> drive_out[3])
    else $error("Stop output missing at corrected target.");
  slip_diff_a: assert property (operating_mode_select == MODE_SLIP && !final_scale_en
      |-> cmp_val[3] == scaled[0] - scaled[1])
    else $error("Slip compare value is not the scaled difference.");
  rad_ignore_a: assert property (operating_mode_select == MODE_RADIUS
      |=> $stable(cnt_q[1]))
    else $error("Encoder two counted in radius mode.");
  mm_order_a: assert property (mm_valid_q |-> mm_min_q <= mm_max_q)
    else $error("Minimum above maximum.");
  mm_clear_a: assert property (start_cmd |=> !mm_valid_q)
    else $error("Extremes not cleared on reset.");
  entry_wrap_a: assert property (scroll_cmd && entry_q == n_entries - 1 &&
      $stable(operating_mode_select) |=> entry_q == ENT_MAIN)
    else $error("Scroll did not wrap.");
  slip_rst_a: assert property (auto_rst |=> cnt_q[0] == 0 && cnt_q[1] == 0)
    else $error("Periodic reset did not clear counters.");

  cut_cycle_c: cover property (cut_st_q == CUT_RUN ##1 cut_st_q == CUT_DWELL);
  auto_rst_c:  cover property (auto_rst);
  scroll_c:    cover property (scroll_cmd && entry_q == ENT_AUX2);
  radius_c:    cover property (trig_rise && operating_mode_select == MODE_RADIUS);
endmodule
`default_nettype wire

//--- core/wcs_pkg.sv
/*
  Shared constants and carrier types for the winding, cut-to-length and slip
  counter mode logic. Assumes a single 20 MHz core clock.
*/
`default_nettype none
package wcs_pkg;

  localparam int CNT_W = 32;
  localparam int SCL_W = 16;
  localparam int NCMD  = 4;

  // Operating mode codes.
  localparam logic [3:0] MODE_RADIUS = 4'h6;
  localparam logic [3:0] MODE_CUT_A  = 4'h7;
  localparam logic [3:0] MODE_CUT_B  = 4'h8;
  localparam logic [3:0] MODE_SLIP   = 4'h9;

  // Clock rate and derived timing.
  localparam longint CLK_HZ         = 64'd20_000_000;
  localparam longint DISP_BASE_MS   = 64'd8;
  localparam longint TENTH_MS       = 64'd100;
  localparam longint CUT_DWELL_MS   = 64'd100;
  localparam int     DISP_BASE_CYC  = int'(DISP_BASE_MS * CLK_HZ / 64'd1000);
  localparam int     TENTH_CYC      = int'(TENTH_MS * CLK_HZ / 64'd1000);
  localparam int     CUT_DWELL_CYC  = int'(CUT_DWELL_MS * CLK_HZ / 64'd1000);
  localparam logic [9:0] AUTO_RST_MAX = 10'h3e7;
  localparam logic [3:0] REFRESH_MAX  = 4'hc;

  // Display entries and blink timing, in base ticks.
  localparam logic [2:0] ENT_MAIN = 3'h0;
  localparam logic [2:0] ENT_MIN  = 3'h1;
  localparam logic [2:0] ENT_MAX  = 3'h2;
  localparam logic [2:0] ENT_AUX1 = 3'h3;
  localparam logic [2:0] ENT_AUX2 = 3'h4;
  localparam logic [2:0] ENT_N5   = 3'h5;
  localparam logic [2:0] ENT_N3   = 3'h3;
  localparam int BLINK_FAST_BIT = 3;
  localparam int BLINK_SLOW_BIT = 5;
  localparam int FRAC_BITS      = 8;

  typedef logic signed [CNT_W-1:0] wcs_cnt_t;

  typedef struct packed {
    wcs_cnt_t tool_width;
    wcs_cnt_t cut_length;
    wcs_cnt_t prestop_distance;
    wcs_cnt_t overshoot_correction;
  } wcs_cut_cfg_t;

  typedef struct packed {
    logic [3:0] pulse_mode;
    logic [3:0] compare_sense;
  } wcs_out_cfg_t;

  typedef wcs_cnt_t [3:0] wcs_presets_t;

  typedef enum logic [1:0] {
    CUT_IDLE  = 2'b00,
    CUT_RUN   = 2'b01,
    CUT_DWELL = 2'b11
  } wcs_cut_st_t;

endpackage
`default_nettype wire

//--- core/wcs_quad_dec.sv
/*
  Quadrature decoder for one encoder: synchronises A and B and gives a
  one-cycle step pulse with direction. Assumes pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module wcs_quad_dec (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic a_pin,
  input  wire logic b_pin,
  output logic      step,
  output logic      up
);
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] prev_q;
  logic [2:0] prime_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_q   <= 2'h0;
      s2_q   <= 2'h0;
      prev_q <= 2'h0;
      prime_q <= 3'h0;
    end else begin
      s1_q   <= {a_pin, b_pin};
      s2_q   <= s1_q;
      prev_q <= s2_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // Gray sequence 00-10-11-01 counts up; a double jump is dropped as noise.
  always_comb begin
    step = 1'b0;
    up   = 1'b0;
    case ({prev_q, s2_q})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
        step = 1'b1;
        up   = 1'b1;
      end
      4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
        step = 1'b1;
      end
      default: begin
        step = 1'b0;
      end
    endcase
    // Until the flops hold real pin levels, a step would only be a reset artefact.
    // A genuine transition in those first cycles is lost, which the user must allow for.
    if (!prime_q[2]) begin
      step = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verif/wcs_enc_model.sv
/*
  Model of the far side: two quadrature encoders and the roll trigger.
  Assumes the bench calls its tasks and that core_clk runs freely.
*/
`timescale 1ns/100ps
`default_nettype none
module wcs_enc_model (
  input  wire logic core_clk,
  output logic [1:0] a_pin,
  output logic [1:0] b_pin,
  output logic       trig_pin
);
  logic [1:0] ph [2];
  initial begin
    ph[0] = 2'h0;
    ph[1] = 2'h0;
    a_pin = 2'h0;
    b_pin = 2'h0;
    trig_pin = 1'b0;
  end
  // One Gray step per loop pass keeps x4 decoding single; levels hold 4 cycles.
  task automatic move(input int enc, input int n);
    for (int i = 0; i < ((n < 0) ? -n : n); i++) begin
      @(negedge core_clk);
      ph[enc] = (n < 0) ? ph[enc] - 2'h1 : ph[enc] + 2'h1;
      a_pin[enc] = ph[enc][1] ^ ph[enc][0];
      b_pin[enc] = ph[enc][1];
      repeat (3) @(negedge core_clk);
    end
  endtask
  task automatic trigger();
    @(negedge core_clk);
    trig_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    trig_pin = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- verif/winding_cut_slip_counter_modes_tb.sv
/*
  Self-checking bench for the mode logic with shortened timing parameters.
  Assumes the encoder model drives the quadrature and trigger pins.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module winding_cut_slip_counter_modes_tb;
  import wcs_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [3:0]   mode = MODE_RADIUS;
  logic [1:0]   a_pin, b_pin;
  logic         trig;
  logic [3:0]   cmd_pin = 4'h0;
  logic [15:0]  scl1 = 16'h0100, scl2 = 16'h0100, fscl = 16'h0100;
  logic [15:0]  sa = 16'h0001;
  logic [4:0]   sb = 5'h00;
  wcs_cnt_t     core_rad = 32'sh0;
  wcs_presets_t presets = '0;
  wcs_cut_cfg_t cut = '{32'sh2, 32'sha, 32'sh4, 32'sh1};
  wcs_out_cfg_t ocfg = '{4'h0, 4'h6};
  logic         load_sel = 1'b0;
  logic         fen = 1'b0, auto_cut = 1'b0;
  logic [9:0]   ari = 10'h0;
  logic [3:0]   drr = 4'h0;
  int           hi;
  logic [3:0]   drive_out;
  wcs_cnt_t     disp_value, analog_value;
  logic [2:0]   disp_entry;
  logic         red, yel;
  int           error_cnt = 0;
  int           n_tests = 0;
  initial forever #25 core_clk = ~core_clk;
  wcs_enc_model enc_u (.core_clk(core_clk), .a_pin(a_pin), .b_pin(b_pin), .trig_pin(trig));
  wcs_modes #(.DISP_BASE_CYC(20), .TENTH_CYC(50), .CUT_DWELL_CYC(10)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .operating_mode_select(mode),
    .enc_a_pin(a_pin), .enc_b_pin(b_pin), .roll_trigger_pin(trig),
    .cmd_pin(cmd_pin), .cmd_is_reset(4'h1), .cmd_is_scroll(4'h2),
    .impulse_scale_1(scl1), .impulse_scale_2(scl2), .final_scale_en(fen),
    .final_scale(fscl), .auto_scale_param_a(sa), .auto_scale_param_b(sb),
    .core_radius_setting(core_rad), .user_presets(presets), .cut_cfg(cut),
    .reset_load_select(load_sel), .out_cfg(ocfg), .auto_cut_restart(auto_cut),
    .auto_reset_interval(ari), .display_refresh_rate(drr),
    .drive_out(drive_out), .disp_value(disp_value), .disp_entry(disp_entry),
    .red_indicator(red), .yellow_indicator(yel), .analog_value(analog_value));
  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] m);
    @(negedge core_clk);
    rst_b = 1'b0;
    mode = m;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  // A key pulse must outlast the synchroniser, so it is held for four cycles.
  task automatic press(input int idx);
    cmd_pin[idx] = 1'b1;
    repeat (4) @(negedge core_clk);
    cmd_pin[idx] = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    do_reset(MODE_CUT_A);
    `CHK(drive_out, 4'h6)
    `CHK(disp_entry, 3'h0)
    press(0);
    for (int k = 0; k <= 11; k++) begin
      repeat (3) @(negedge core_clk);
      `CHK(disp_value, wcs_cnt_t'(k))
      `CHK(analog_value, wcs_cnt_t'(k))
      `CHK(drive_out, {k >= 11, k <= 10, k <= 8, 1'b0})
      enc_u.move(0, 1);
    end
    load_sel = 1'b1;
    do_reset(MODE_CUT_B);
    press(0);
    repeat (3) @(negedge core_clk);
    `CHK(disp_value, -32'sh2)
    `CHK(drive_out, 4'h6)
    enc_u.move(0, 13);
    repeat (3) @(negedge core_clk);
    `CHK(drive_out, 4'h8)
    press(0);
    auto_cut = 1'b1;
    enc_u.move(0, 11);
    repeat (20) @(negedge core_clk);
    `CHK(disp_value, -32'sh2)
    `CHK(drive_out, 4'h6)
    presets[0] = 32'sh2;
    presets[1] = -32'sh1;
    presets[2] = 32'sh64;
    presets[3] = 32'sh64;
    ocfg = '{4'h0, 4'h2};
    do_reset(MODE_SLIP);
    enc_u.move(0, 3);
    enc_u.move(1, 1);
    repeat (3) @(negedge core_clk);
    `CHK(disp_value, 32'sh2)
    `CHK(drive_out, 4'h1)
    enc_u.move(1, 5);
    repeat (3) @(negedge core_clk);
    `CHK(disp_value, -32'sh3)
    `CHK(drive_out, 4'h2)
    fen = 1'b1;
    fscl = 16'h0200;
    repeat (2) @(negedge core_clk);
    `CHK(disp_value, -32'sh6)
    drr = 4'h2;
    enc_u.move(0, 1);
    for (int w = 0; w < 60 && disp_value !== -32'sh4; w++) @(negedge core_clk);
    `CHK(disp_value, -32'sh4)
    enc_u.move(0, 1);
    `CHK(disp_value, -32'sh4)
    repeat (40) @(negedge core_clk);
    `CHK(disp_value, -32'sh2)
    drr = 4'h0;
    ari = 10'h1;
    repeat (60) @(negedge core_clk);
    `CHK(disp_value, 32'sh0)
    core_rad = 32'sh1;
    do_reset(MODE_RADIUS);
    enc_u.trigger();
    enc_u.move(0, 4);
    enc_u.move(1, 3);
    enc_u.trigger();
    repeat (4) @(negedge core_clk);
    `CHK(disp_value, 32'sh3)
    for (int s = 1; s <= 5; s++) begin
      press(1);
      `CHK(disp_entry, 3'(s % 5))
      if (s == 3) `CHK(disp_value, 32'sh4)
      if (s == 2) `CHK(disp_value, 32'sh3)
      if (s == 4) `CHK(disp_value, 32'sh4)
      if (s == 5) `CHK({red, yel}, 2'h0)
      if (s == 1) begin
        `CHK(disp_value, -32'sh1)
        hi = 0;
        repeat (320) begin
          @(negedge core_clk);
          hi += red;
        end
        `CHK(hi, 160)
        `CHK(yel, 1'b0)
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
